//--- design/esi_regs.svh
/*
  Constants of the extended stack instruction unit: opcode patterns,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the package or design files.
*/
`ifndef ESI_REGS_SVH
`define ESI_REGS_SVH
// ==========================================================
// Opcode patterns
`define ESI_OP_ADDPTR   8'hE8
`define ESI_OP_SUBPTR   8'hE9
`define ESI_OP_PUSHLIT  8'hEA
`define ESI_OP_MOVIDX   8'hEB
`define ESI_OP_WORD2    4'hF
`define ESI_OP_CALLREG  16'h0014
`define ESI_SEL_FRAME   2'h3
// ==========================================================
// Field positions and limits
`define ESI_SEL_MSB     7
`define ESI_SEL_LSB     6
`define ESI_MOV_KIND    7
`define ESI_OFS_LIMIT   8'h5F
`define ESI_RET_STEP    21'h000002
`define ESI_PTR_RESET   12'h000
// ==========================================================
// Indirect-addressing register window, FDBh..FEFh (all three pointer sets)
`define ESI_IND_LO      12'hFDB
`define ESI_IND_HI      12'hFEF
`define ESI_CYC_SLOW    2
`endif

//--- design/esi_pkg.sv
/*
  Types of the extended stack instruction unit.
  Assumes esi_regs.svh is reachable on the include path.
*/
package esi_pkg;
  // ==========================================================
  // Decoder states, Gray coded along fetch -> second cycle
  typedef enum logic [1:0] {
    ESI_EXEC  = 2'b00,
    ESI_NOP2  = 2'b01,
    ESI_MOV2  = 2'b10
  } esi_state_t;

  // Data memory request
  typedef struct packed {
    logic        we;
    logic        re;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } esi_mem_req_t;

  // Program counter control
  typedef struct packed {
    logic        load;
    logic        push;
    logic [20:0] target;
    logic [20:0] ret_addr;
  } esi_pc_ctl_t;
endpackage

//--- design/esi_ptr_bank.sv
/*
  Bank of three 12-bit file select pointers with add, subtract and
  decrement updates, wrapping modulo 4096.
  Assumes one update request per cycle from the decoder.
*/
module esi_ptr_bank (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Update request
  input  wire logic        upd,
  input  wire logic [1:0]  sel,
  input  wire logic        sub,
  input  wire logic [5:0]  lit,
  // Pointer values
  output logic      [11:0] ptr0,
  output logic      [11:0] ptr1,
  output logic      [11:0] ptr2
);
  `include "esi_regs.svh"
  logic [11:0] delta;

  // Literal widened to pointer width
  assign delta = {6'h00, lit};

  // ==========================================================
  // Pointer update; 12-bit arithmetic wraps by itself
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr0 <= `ESI_PTR_RESET;
      ptr1 <= `ESI_PTR_RESET;
      ptr2 <= `ESI_PTR_RESET;
    end else if (upd) begin
      unique case (sel)
        2'h0: ptr0 <= sub ? ptr0 - delta : ptr0 + delta;
        2'h1: ptr1 <= sub ? ptr1 - delta : ptr1 + delta;
        default: ptr2 <= sub ? ptr2 - delta : ptr2 + delta;
      endcase
    end
  end
endmodule // esi_ptr_bank

//--- design/esi_unit.sv
/*
  Decode and execute logic of the extended stack instruction set.
  Assumes the core presents each instruction word with instr_valid,
  answers a read request with data while that request stands, and
  shares sys_clk and rst with this unit.
*/
// Function
// - Extension inactive unless enable bit set
// - Add 6-bit literal to pointer, one cycle
// - Select 11 means frame add-and-return
// - Add-and-return then loads pc from stack
// - Add-and-return takes two cycles, second idle
// - Subtract forms mirror the add forms
// - Push literal at frame pointer, decrement
// - Indirect call pushes pc plus two
// - Pc bytes from working register and latches
// - Indirect call two cycles, no flag changes
// - Indexed-to-register move: frame offset, absolute
// - Indexed-to-indexed move: both frame offsets
// - Indirect-register source reads as zero
// - Indexed-to-indexed indirect-register destination suppresses write
// - Moves reach whole 4096-byte data space
// - Low access operands become frame offsets
module esi_unit
  import esi_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Configuration
  input  wire logic                  extension_enable_bit,
  // Instruction stream
  input  wire logic                  instr_valid,
  input  wire logic [15:0]           instr_word,
  input  wire logic [20:0]           pc_now,
  // Core state
  input  wire logic [7:0]            working_register,
  input  wire logic [7:0]            pc_high_latch,
  input  wire logic [7:0]            pc_upper_latch,
  input  wire logic [20:0]           top_of_return_stack,
  // Standard operand remap
  input  wire logic                  std_access_bit,
  input  wire logic [7:0]            std_operand,
  output logic                       std_indexed,
  output logic      [11:0]           std_addr,
  // Data memory
  input  wire logic [7:0]            mem_rdata,
  output esi_pkg::esi_mem_req_t      mem_req,
  // Program counter and sequencing
  output esi_pkg::esi_pc_ctl_t       pc_ctl,
  output logic                       busy,
  output logic                       ext_hit,
  // Pointer values
  output logic      [11:0]           ptr0,
  output logic      [11:0]           ptr1,
  output logic      [11:0]           ptr2
);
  import esi_pkg::*;
  `include "esi_regs.svh"

  esi_state_t  state_r;
  logic [7:0]  op_hi;
  logic [1:0]  sel;
  logic        go;
  logic        is_add;
  logic        is_sub;
  logic        is_push;
  logic        is_call;
  logic        is_mov;
  logic        mov_kind_r;
  logic [11:0] src_addr;
  logic        src_ind_r;
  logic        upd;
  logic        upd_sub;
  logic [1:0]  upd_sel;
  logic [5:0]  upd_lit;
  logic [11:0] dst_addr;
  logic        dst_ind;

  // ==========================================================
  // Decode
  assign op_hi   = instr_word[15:8];
  assign sel     = instr_word[`ESI_SEL_MSB:`ESI_SEL_LSB];
  assign go      = instr_valid && extension_enable_bit && state_r == ESI_EXEC;
  assign is_add  = go && op_hi == `ESI_OP_ADDPTR;
  assign is_sub  = go && op_hi == `ESI_OP_SUBPTR;
  assign is_push = go && op_hi == `ESI_OP_PUSHLIT;
  assign is_call = go && instr_word == `ESI_OP_CALLREG;
  assign is_mov  = go && op_hi == `ESI_OP_MOVIDX;

  // Pointer update request; push reuses the bank as a decrement by one
  assign upd     = is_add || is_sub || is_push;
  assign upd_sub = is_sub || is_push;
  assign upd_sel = is_push ? 2'h2 : (sel == `ESI_SEL_FRAME ? 2'h2 : sel);
  assign upd_lit = is_push ? 6'h01 : instr_word[5:0];

  esi_ptr_bank u_ptrs (
    .sys_clk (sys_clk),
    .rst     (rst),
    .upd     (upd),
    .sel     (upd_sel),
    .sub     (upd_sub),
    .lit     (upd_lit),
    .ptr0    (ptr0),
    .ptr1    (ptr1),
    .ptr2    (ptr2)
  );

  // Frame-relative addresses; 12 bits cover 000h..FFFh
  assign src_addr = ptr2 + {5'h00, instr_word[6:0]};
  assign dst_addr = mov_kind_r ? ptr2 + {5'h00, instr_word[6:0]} : instr_word[11:0];
  assign dst_ind  = mov_kind_r && dst_addr >= `ESI_IND_LO && dst_addr <= `ESI_IND_HI;

  // ==========================================================
  // Sequencer: two-cycle forms hold busy for their second cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ESI_EXEC;
    end else begin
      unique case (state_r)
        ESI_EXEC: begin
          if ((is_add || is_sub) && sel == `ESI_SEL_FRAME) begin
            state_r <= ESI_NOP2;
          end else if (is_call) begin
            state_r <= ESI_NOP2;
          end else if (is_mov) begin
            state_r <= ESI_MOV2;
          end
        end
        ESI_NOP2: state_r <= ESI_EXEC;
        ESI_MOV2: begin
          if (instr_valid) begin
            state_r <= ESI_EXEC;
          end
        end
        default: state_r <= ESI_EXEC;
      endcase
    end
  end

  // Move context from the first word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mov_kind_r <= 1'b0;
      src_ind_r  <= 1'b0;
    end else if (is_mov) begin
      mov_kind_r <= instr_word[`ESI_MOV_KIND];
      src_ind_r  <= src_addr >= `ESI_IND_LO && src_addr <= `ESI_IND_HI;
    end
  end

  // ==========================================================
  // Data memory requests
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_req <= '0;
    end else if (is_push) begin
      mem_req <= '{we: 1'b1, re: 1'b0, addr: ptr2, wdata: instr_word[7:0]};
    end else if (is_mov) begin
      mem_req <= '{we: 1'b0, re: 1'b1, addr: src_addr, wdata: 8'h00};
    end else if (state_r == ESI_MOV2 && !instr_valid) begin
      // Keep the read standing so the source byte is still there when word two comes
      mem_req <= mem_req;
    end else if (state_r == ESI_MOV2 && instr_valid && instr_word[15:12] == `ESI_OP_WORD2) begin
      // Pc and stack bytes are never destinations, so no guard here
      mem_req <= '{we: !dst_ind, re: 1'b0, addr: dst_addr,
                   wdata: src_ind_r ? 8'h00 : mem_rdata};
    end else begin
      mem_req <= '0;
    end
  end

  // Program counter control; working register and flags untouched
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_ctl <= '0;
    end else if (is_call) begin
      pc_ctl <= '{load: 1'b1, push: 1'b1,
                  target: {pc_upper_latch[4:0], pc_high_latch, working_register},
                  ret_addr: pc_now + `ESI_RET_STEP};
    end else if ((is_add || is_sub) && sel == `ESI_SEL_FRAME) begin
      pc_ctl <= '{load: 1'b1, push: 1'b0, target: top_of_return_stack, ret_addr: 21'h000000};
    end else begin
      pc_ctl <= '0;
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy    <= 1'b0;
      ext_hit <= 1'b0;
    end else begin
      busy    <= ((is_add || is_sub) && sel == `ESI_SEL_FRAME) || is_call || is_mov;
      ext_hit <= is_add || is_sub || is_push || is_call || is_mov;
    end
  end

  // Standard operand remap to frame-relative
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      std_indexed <= 1'b0;
      std_addr    <= 12'h000;
    end else begin
      std_indexed <= extension_enable_bit && !std_access_bit && std_operand <= `ESI_OFS_LIMIT;
      std_addr    <= ptr2 + {4'h0, std_operand};
    end
  end

  // ==========================================================
  // Checks
  sequence s_frame_ret;
    (is_add || is_sub) && sel == `ESI_SEL_FRAME;
  endsequence
  sequence s_two_idle;
    ##1 busy ##1 !busy;
  endsequence

  AST_DISABLED_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !extension_enable_bit |=> !ext_hit) else $error("extension acted while disabled");
  AST_ADD_PTR: assert property (@(posedge sys_clk) disable iff (rst)
    is_add && sel == 2'h0 |=> ptr0 == $past(ptr0) + {6'h00, $past(instr_word[5:0])})
    else $error("pointer add wrong");
  AST_FRAME_ONLY: assert property (@(posedge sys_clk) disable iff (rst)
    is_add && sel == `ESI_SEL_FRAME |=> ptr0 == $past(ptr0) && ptr1 == $past(ptr1))
    else $error("frame variant touched other pointer");
  AST_RET_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
    s_frame_ret |=> pc_ctl.load && pc_ctl.target == $past(top_of_return_stack))
    else $error("return target not loaded");
  AST_TWO_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
    s_frame_ret |-> s_two_idle) else $error("return variant not two cycles");
  AST_SUB_FRAME: assert property (@(posedge sys_clk) disable iff (rst)
    is_sub && sel == `ESI_SEL_FRAME |=> ptr2 == $past(ptr2) - {6'h00, $past(instr_word[5:0])})
    else $error("frame subtract wrong");
  AST_PUSH: assert property (@(posedge sys_clk) disable iff (rst)
    is_push |=> mem_req.we && mem_req.addr == $past(ptr2) && ptr2 == $past(ptr2) - 12'h001)
    else $error("push literal wrong");
  AST_CALL_RET: assert property (@(posedge sys_clk) disable iff (rst)
    is_call |=> pc_ctl.push && pc_ctl.ret_addr == $past(pc_now) + `ESI_RET_STEP)
    else $error("call return address wrong");
  AST_CALL_TGT: assert property (@(posedge sys_clk) disable iff (rst)
    is_call |=> pc_ctl.target[7:0] == $past(working_register) && pc_ctl.target[15:8] == $past(pc_high_latch))
    else $error("call target wrong");
  AST_CALL_LEN: assert property (@(posedge sys_clk) disable iff (rst)
    is_call |-> s_two_idle) else $error("call not two cycles");
  AST_DST_NOP: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ESI_MOV2 && instr_valid && dst_ind |=> !mem_req.we) else $error("write to indirect register");
endmodule // esi_unit

//--- tb/esi_mem_model.sv
/*
  Data memory model that stands behind the unit's memory request port.
  Assumes one request per cycle; read data stand while re stands.
*/
module esi_mem_model
  import esi_pkg::*;
(
  // Clock
  input  wire logic                  sys_clk,
  // Request and answer
  input  wire esi_pkg::esi_mem_req_t mem_req,
  output logic      [7:0]            mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem_r [4096];
  logic [7:0] idle_r = 8'hA5;

  // ==========================================================
  // Storage
  // Whole 12-bit space is backed, so moves may reach any byte
  always_ff @(posedge sys_clk) begin
    if (mem_req.we) begin
      mem_r[mem_req.addr] <= mem_req.wdata;
    end
  end

  // Idle value toggles each cycle so stale data never matches
  always_ff @(posedge sys_clk) begin
    idle_r <= ~idle_r;
  end

  // Read data answer the registered request in the cycle that it stands
  assign mem_rdata = mem_req.re ? mem_r[mem_req.addr] : idle_r;
endmodule // esi_mem_model

//--- tb/esi_unit_tb.sv
/*
  Testbench of the extended stack instruction unit: a reset case, a table of
  pointer operations, then hand-written push, return, call and move cases.
  Assumes esi_mem_model answers the unit's reads in the cycle that they stand.
*/
module esi_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, ex, sn) \
  begin comparisons++; if ((sn) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, sn); end end

  // ==========================================================
  // Stimulus and observed signals
  logic                  sys_clk              = 1'b0;
  logic                  rst                  = 1'b1;
  logic                  extension_enable_bit = 1'b0;
  logic                  instr_valid          = 1'b0;
  logic [15:0]           instr_word           = 16'h0000;
  logic [20:0]           pc_now               = 21'h001000;
  logic [7:0]            working_register     = 8'h06;
  logic [7:0]            pc_high_latch        = 8'h10;
  logic [7:0]            pc_upper_latch       = 8'h01;
  logic [20:0]           top_of_return_stack  = 21'h012345;
  logic                  std_access_bit       = 1'b0;
  logic [7:0]            std_operand          = 8'h00;
  logic                  std_indexed, busy, ext_hit;
  logic [11:0]           std_addr, ptr0, ptr1, ptr2;
  logic [7:0]            mem_rdata;
  esi_pkg::esi_mem_req_t mem_req;
  esi_pkg::esi_pc_ctl_t  pc_ctl;
  int                    miscompares = 0;
  int                    comparisons = 0;
  int                    cyc         = 0;

  // Ordinary cases: word, then pointers and hit expected after it
  typedef struct packed {logic [15:0] w; logic [11:0] p0, p1, p2; logic hit;} esi_row_t;
  esi_row_t rows [7] = '{
    '{16'hE83F, 12'h03F, 12'h000, 12'h000, 1'b1}, '{16'hE841, 12'h03F, 12'h001, 12'h000, 1'b1},
    '{16'hE881, 12'h03F, 12'h001, 12'h001, 1'b1}, '{16'hE902, 12'h03D, 12'h001, 12'h001, 1'b1},
    '{16'hE942, 12'h03D, 12'hFFF, 12'h001, 1'b1}, '{16'hE8BF, 12'h03D, 12'hFFF, 12'h040, 1'b1},
    '{16'h0000, 12'h03D, 12'hFFF, 12'h040, 1'b0}};

  esi_unit esi_unit_inst (.sys_clk(sys_clk), .rst(rst), .extension_enable_bit(extension_enable_bit),
    .instr_valid(instr_valid), .instr_word(instr_word), .pc_now(pc_now), .working_register(working_register),
    .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch), .top_of_return_stack(top_of_return_stack),
    .std_access_bit(std_access_bit), .std_operand(std_operand), .std_indexed(std_indexed),
    .std_addr(std_addr), .mem_rdata(mem_rdata), .mem_req(mem_req), .pc_ctl(pc_ctl), .busy(busy),
    .ext_hit(ext_hit), .ptr0(ptr0), .ptr1(ptr1), .ptr2(ptr2));
  esi_mem_model esi_mem_model_inst (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ==========================================================
  // Clock, and a ceiling well above the few dozen cycles needed
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================================
  // Tasks
  // Word one for one edge, then word two (held valid if v2) and settle
  task automatic issue(input logic [15:0] w1, w2, input logic v2);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= w1;
    @(posedge sys_clk);
    instr_valid <= v2;
    instr_word  <= w2;
    #1;
  endtask

  task automatic idle();
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Move: read address checked if src[12]; write {we, addr, data} next
  task automatic move(input logic [15:0] w1, w2, input logic [12:0] src, input logic [20:0] wr);
    issue(w1, w2, 1'b1);
    if (src[12]) `CHK("move read", {2'b11, src[11:0]}, {mem_req.re, busy, mem_req.addr});
    idle();
    `CHK("move write", wr, wr[20] ? {mem_req.we, mem_req.addr, mem_req.wdata} : {mem_req.we, 20'h0});
  endtask

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK("reset state", 39'h0, {ptr0, ptr1, ptr2, busy, ext_hit, pc_ctl.load});
    issue(16'hE801, 16'h0000, 1'b0);
    `CHK("disabled", 13'h0, {ext_hit, ptr0});
    @(posedge sys_clk) extension_enable_bit <= 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].w, 16'h0000, 1'b0);
      `CHK("ptrs", {rows[i].p0, rows[i].p1, rows[i].p2}, {ptr0, ptr1, ptr2});
      `CHK("ext_hit", rows[i].hit, ext_hit);
    end
    issue(16'hEA5A, 16'h0000, 1'b0);
    `CHK("push", {2'b10, 12'h040, 8'h5A, 12'h03F}, {mem_req, ptr2});
    issue(16'hE8C3, 16'h0000, 1'b0);
    `CHK("addret pc", {1'b1, 21'h012345}, {pc_ctl.load, pc_ctl.target});
    `CHK("addret ptrs", {12'h03D, 12'hFFF, 12'h042, 1'b1}, {ptr0, ptr1, ptr2, busy});
    idle();
    `CHK("addret end", 2'b00, {busy, pc_ctl.load});
    issue(16'hE9C3, 16'h0000, 1'b0);
    `CHK("subret", {1'b1, 12'h03F, 1'b1}, {pc_ctl.load, ptr2, busy});
    idle();
    // Call with an extended word offered during its idle cycle
    issue(16'h0014, 16'hE801, 1'b1);
    `CHK("call", {3'b111, 21'h011006, 21'h001002},
      {pc_ctl.load, pc_ctl.push, busy, pc_ctl.target, pc_ctl.ret_addr});
    idle();
    `CHK("refused", {1'b0, 12'h03D}, {ext_hit, ptr0});
    // Destinations stay clear of pc and stack bytes
    move(16'hEB01, 16'hF000, {1'b1, 12'h040}, {1'b1, 12'h000, 8'h5A});
    issue(16'hE9BF, 16'h0000, 1'b0);
    issue(16'hE9A5, 16'h0000, 1'b0);
    `CHK("frame low", 12'hFDB, ptr2);
    move(16'hEB80, 16'hF07F, 13'h0000, {1'b1, 12'h05A, 8'h00});
    move(16'hEBFF, 16'hF000, {1'b1, 12'h05A}, 21'h000000);
    // Standard operand remap, one cycle behind its inputs
    @(posedge sys_clk) std_operand <= 8'h5F;
    @(posedge sys_clk) std_operand <= 8'h60;
    #1;
    `CHK("remap", {1'b1, 12'h03A}, {std_indexed, std_addr});
    @(posedge sys_clk) begin
      std_access_bit <= 1'b1;
      std_operand    <= 8'h05;
    end
    #1;
    `CHK("high operand", 1'b0, std_indexed);
    @(posedge sys_clk);
    #1;
    `CHK("no remap", {1'b0, 12'hFE0}, {std_indexed, std_addr});
    test_done();
  end
endmodule // esi_unit_tb
